// File: hdl/ccb_bridge_cfg.sv
`timescale 1ns/100ps
module ccb_bridge_cfg
	import ccb_pkg::*;
#(
	parameter int WD_SLOW_CYC = CCB_WD_SLOW_CYC,
	parameter int WD_FAST_CYC = CCB_WD_FAST_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rd_data,
	input wire logic txn_valid,
	input wire logic [6:0] txn_addr,
	output logic fwd_valid,
	output logic [6:0] fwd_addr,
	output logic fwd_remapped,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe_n,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic sda_req,
	output logic bus_free,
	output logic rmt_wr_refused,
	input wire logic clk_link,
	input wire logic srst_link,
	input wire logic lnk_seq_err,
	input wire logic lnk_id_valid,
	input wire logic [6:0] lnk_id,
	input wire logic lnk_wr_valid,
	input wire logic [7:0] lnk_wr_addr,
	input wire logic [7:0] lnk_wr_data
);

	localparam logic [27:0] WD_SLOW_LIM = 28'(WD_SLOW_CYC - 1);
	localparam logic [27:0] WD_FAST_LIM = 28'(WD_FAST_CYC - 1);
	localparam logic [27:0] RCV_HALF_LIM = 28'(CCB_RCV_HALF_CYC - 1);
	localparam logic [3:0] RCV_LAST = 4'(CCB_RCV_PULSES - 1);

	// Events and words arriving from the link domain.
	logic seq_evt;
	logic id_evt;
	logic [6:0] id_word;
	logic rw_evt;
	logic [15:0] rw_word;

	// Register state.
	logic pass_all;
	logic [6:0] ctrl1_rest;
	logic seq_err, seq_clr, wr_lock, wd_fast, wd_off;
	logic [1:0] sda_dly;
	logic id_hold;
	logic [6:0] id_addr, tgt0, tgt1, alias0, alias1;
	logic next_pass_all;
	logic [6:0] next_ctrl1_rest;
	logic next_seq_err, next_seq_clr, next_wr_lock, next_wd_fast, next_wd_off;
	logic [1:0] next_sda_dly;
	logic next_id_hold;
	logic [6:0] next_id_addr, next_tgt0, next_tgt1, next_alias0, next_alias1;
	logic [7:0] next_reg_rd_data;
	logic next_rmt_wr_refused;
	logic eff_wr;
	logic [7:0] eff_addr, eff_data;

	// Pin synchronisers.
	logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
	logic bus_act;

	// Remap state.
	logic next_fwd_valid, next_fwd_remapped;
	logic [6:0] next_fwd_addr;

	// Watchdog state.
	ccb_wd_state_t wd_state, next_wd_state;
	logic [27:0] wd_cnt, next_wd_cnt, wd_lim;
	logic [3:0] pulse_cnt, next_pulse_cnt;
	logic scl_drv, next_scl_drv, next_bus_free;

	// SDA output delay state.
	logic [7:0] dly_cnt, next_dly_cnt, dly_lim;
	logic dly_run, next_dly_run, sda_drv, next_sda_drv;

	// Link-side crossings; the link runs far slower, so events never overrun the handshake.
	ccb_xfer #(.W(1)) u_seq_xfer (
		.clk_src(clk_link),
		.srst_src(srst_link),
		.src_valid(lnk_seq_err),
		.src_data(1'b1),
		.clk_dst(clk_sys),
		.srst_dst(srst),
		.ce(ce),
		.dst_valid(seq_evt),
		.dst_data()
	);

	ccb_xfer #(.W(7)) u_id_xfer (
		.clk_src(clk_link),
		.srst_src(srst_link),
		.src_valid(lnk_id_valid),
		.src_data(lnk_id),
		.clk_dst(clk_sys),
		.srst_dst(srst),
		.ce(ce),
		.dst_valid(id_evt),
		.dst_data(id_word)
	);

	ccb_xfer #(.W(16)) u_wr_xfer (
		.clk_src(clk_link),
		.srst_src(srst_link),
		.src_valid(lnk_wr_valid),
		.src_data({lnk_wr_addr, lnk_wr_data}),
		.clk_dst(clk_sys),
		.srst_dst(srst),
		.ce(ce),
		.dst_valid(rw_evt),
		.dst_data(rw_word)
	);

	// A local write wins a collision; the remote one is then dropped and flagged.
	always_comb begin
		eff_wr = reg_wr | (rw_evt & ~wr_lock);
		eff_addr = reg_wr ? reg_addr : rw_word[15:8];
		eff_data = reg_wr ? reg_wdata : rw_word[7:0];
		next_rmt_wr_refused = rw_evt & (wr_lock | reg_wr);
	end

	// Register file: writes, auto-load of the remote address, error flag and reads.
	always_comb begin
		next_pass_all = pass_all;
		next_ctrl1_rest = ctrl1_rest;
		next_seq_clr = seq_clr;
		next_sda_dly = sda_dly;
		next_wr_lock = wr_lock;
		next_wd_fast = wd_fast;
		next_wd_off = wd_off;
		next_id_hold = id_hold;
		next_id_addr = id_addr;
		next_tgt0 = tgt0;
		next_tgt1 = tgt1;
		next_alias0 = alias0;
		next_alias1 = alias1;
		next_reg_rd_data = reg_rd_data;
		if (eff_wr) begin
			case (eff_addr)
				CCB_ADDR_CTRL1: begin
					next_pass_all = eff_data[CCB_C1_PASS_ALL];
					next_ctrl1_rest = eff_data[6:0];
				end
				CCB_ADDR_CTRL2: begin
					next_seq_clr = eff_data[CCB_C2_SEQ_CLR];
					next_sda_dly = eff_data[CCB_C2_SDA_DLY_HI:CCB_C2_SDA_DLY_LO];
					next_wr_lock = eff_data[CCB_C2_WR_LOCK];
					next_wd_fast = eff_data[CCB_C2_WD_FAST];
					next_wd_off = eff_data[CCB_C2_WD_OFF];
				end
				CCB_ADDR_IDENT: begin
					next_id_hold = eff_data[CCB_ID_HOLD];
					if (eff_data[CCB_ID_HOLD]) begin
						next_id_addr = eff_data[CCB_ADDR7_HI:CCB_ADDR7_LO];
					end
				end
				CCB_ADDR_TGT0: next_tgt0 = eff_data[CCB_ADDR7_HI:CCB_ADDR7_LO];
				CCB_ADDR_TGT1: next_tgt1 = eff_data[CCB_ADDR7_HI:CCB_ADDR7_LO];
				CCB_ADDR_ALIAS0: next_alias0 = eff_data[CCB_ADDR7_HI:CCB_ADDR7_LO];
				CCB_ADDR_ALIAS1: next_alias1 = eff_data[CCB_ADDR7_HI:CCB_ADDR7_LO];
				default: begin
				end
			endcase
		end
		// The link may refresh the address only while software has not frozen it.
		if (id_evt && !next_id_hold) begin
			next_id_addr = id_word;
		end
		// The clear bit is a level that masks new errors; the incoming value clears at the writing edge.
		if (next_seq_clr) begin
			next_seq_err = 1'b0;
		end else if (seq_evt) begin
			next_seq_err = 1'b1;
		end else begin
			next_seq_err = seq_err;
		end
		if (reg_rd) begin
			case (reg_addr)
				CCB_ADDR_CTRL1: next_reg_rd_data = {pass_all, ctrl1_rest};
				CCB_ADDR_CTRL2: next_reg_rd_data = {seq_err, seq_clr, 1'b0, sda_dly, wr_lock, wd_fast, wd_off};
				CCB_ADDR_IDENT: next_reg_rd_data = {id_addr, id_hold};
				CCB_ADDR_TGT0: next_reg_rd_data = {tgt0, 1'b0};
				CCB_ADDR_TGT1: next_reg_rd_data = {tgt1, 1'b0};
				CCB_ADDR_ALIAS0: next_reg_rd_data = {alias0, 1'b0};
				CCB_ADDR_ALIAS1: next_reg_rd_data = {alias1, 1'b0};
				default: next_reg_rd_data = CCB_RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pass_all <= CCB_CTRL1_RST[CCB_C1_PASS_ALL];
			ctrl1_rest <= CCB_CTRL1_RST[6:0];
			seq_err <= CCB_CTRL2_RST[CCB_C2_SEQ_ERR];
			seq_clr <= CCB_CTRL2_RST[CCB_C2_SEQ_CLR];
			sda_dly <= CCB_CTRL2_RST[CCB_C2_SDA_DLY_HI:CCB_C2_SDA_DLY_LO];
			wr_lock <= CCB_CTRL2_RST[CCB_C2_WR_LOCK];
			wd_fast <= CCB_CTRL2_RST[CCB_C2_WD_FAST];
			wd_off <= CCB_CTRL2_RST[CCB_C2_WD_OFF];
			id_hold <= 1'b0;
			id_addr <= CCB_ADDR7_RST;
			tgt0 <= CCB_ADDR7_RST;
			tgt1 <= CCB_ADDR7_RST;
			alias0 <= CCB_ADDR7_RST;
			alias1 <= CCB_ADDR7_RST;
			reg_rd_data <= CCB_RD_UNMAPPED;
			rmt_wr_refused <= 1'b0;
		end else if (ce) begin
			pass_all <= next_pass_all;
			ctrl1_rest <= next_ctrl1_rest;
			seq_err <= next_seq_err;
			seq_clr <= next_seq_clr;
			sda_dly <= next_sda_dly;
			wr_lock <= next_wr_lock;
			wd_fast <= next_wd_fast;
			wd_off <= next_wd_off;
			id_hold <= next_id_hold;
			id_addr <= next_id_addr;
			tgt0 <= next_tgt0;
			tgt1 <= next_tgt1;
			alias0 <= next_alias0;
			alias1 <= next_alias1;
			reg_rd_data <= next_reg_rd_data;
			rmt_wr_refused <= next_rmt_wr_refused;
		end
	end

	// Alias match and remap; a zero alias is treated as an empty entry.
	always_comb begin
		next_fwd_valid = 1'b0;
		next_fwd_remapped = 1'b0;
		next_fwd_addr = fwd_addr;
		if (txn_valid) begin
			if (alias0 != CCB_ADDR7_RST && txn_addr == alias0) begin
				next_fwd_valid = 1'b1;
				next_fwd_remapped = 1'b1;
				next_fwd_addr = tgt0;
			end else if (alias1 != CCB_ADDR7_RST && txn_addr == alias1) begin
				next_fwd_valid = 1'b1;
				next_fwd_remapped = 1'b1;
				next_fwd_addr = tgt1;
			end else if (pass_all) begin
				next_fwd_valid = 1'b1;
				next_fwd_addr = txn_addr;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fwd_valid <= 1'b0;
			fwd_remapped <= 1'b0;
			fwd_addr <= CCB_ADDR7_RST;
		end else if (ce) begin
			fwd_valid <= next_fwd_valid;
			fwd_remapped <= next_fwd_remapped;
			fwd_addr <= next_fwd_addr;
		end
	end

	// Bus pins are asynchronous; only the second and third stages feed logic.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
		end else if (ce) begin
			{scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
		end
	end

	assign bus_act = (scl_s2 ^ scl_s3) | (sda_s2 ^ sda_s3);

	// Watchdog: counts idle cycles, then declares the bus free or clocks it loose.
	always_comb begin
		wd_lim = wd_fast ? WD_FAST_LIM : WD_SLOW_LIM;
		next_wd_state = wd_state;
		next_wd_cnt = wd_cnt;
		next_pulse_cnt = pulse_cnt;
		next_scl_drv = scl_drv;
		next_bus_free = bus_free;
		if (wd_off) begin
			next_wd_state = CCB_WD_IDLE;
			next_wd_cnt = '0;
			next_pulse_cnt = '0;
			next_scl_drv = 1'b0;
			next_bus_free = 1'b0;
		end else begin
			case (wd_state)
				CCB_WD_IDLE: begin
					if (bus_act) begin
						next_wd_cnt = '0;
						next_bus_free = 1'b0;
					end else if (wd_cnt >= wd_lim) begin
						next_wd_cnt = wd_lim;
						if (sda_s2) begin
							next_bus_free = 1'b1;
						end else begin
							next_wd_state = CCB_WD_LOW;
							next_wd_cnt = '0;
							next_pulse_cnt = '0;
							next_scl_drv = 1'b1;
						end
					end else begin
						next_wd_cnt = wd_cnt + 28'h1;
					end
				end
				CCB_WD_LOW: begin
					if (wd_cnt == RCV_HALF_LIM) begin
						next_wd_cnt = '0;
						next_scl_drv = 1'b0;
						next_wd_state = CCB_WD_HIGH;
					end else begin
						next_wd_cnt = wd_cnt + 28'h1;
					end
				end
				CCB_WD_HIGH: begin
					if (wd_cnt == RCV_HALF_LIM) begin
						next_wd_cnt = '0;
						if (pulse_cnt == RCV_LAST) begin
							next_wd_state = CCB_WD_IDLE;
							next_pulse_cnt = '0;
						end else begin
							next_pulse_cnt = pulse_cnt + 4'h1;
							next_scl_drv = 1'b1;
							next_wd_state = CCB_WD_LOW;
						end
					end else begin
						next_wd_cnt = wd_cnt + 28'h1;
					end
				end
				default: begin
					next_wd_state = CCB_WD_IDLE;
					next_wd_cnt = '0;
					next_scl_drv = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wd_state <= CCB_WD_IDLE;
			wd_cnt <= '0;
			pulse_cnt <= '0;
			scl_drv <= 1'b0;
			bus_free <= 1'b0;
		end else if (ce) begin
			wd_state <= next_wd_state;
			wd_cnt <= next_wd_cnt;
			pulse_cnt <= next_pulse_cnt;
			scl_drv <= next_scl_drv;
			bus_free <= next_bus_free;
		end
	end

	// SDA output delay: a new data level is released only after SCL has been low for the set time.
	always_comb begin
		dly_lim = 8'(((CCB_SDA_DLY_BASE_NS + CCB_SDA_DLY_STEP_NS * int'(sda_dly)) * CCB_CLK_MHZ + 999) / 1000 - 1);
		next_dly_run = dly_run;
		next_dly_cnt = dly_cnt;
		next_sda_drv = sda_drv;
		if (scl_s3 && !scl_s2) begin
			next_dly_run = 1'b1;
			next_dly_cnt = '0;
		end else if (dly_run) begin
			if (dly_cnt == dly_lim) begin
				next_dly_run = 1'b0;
				next_sda_drv = sda_req;
			end else begin
				next_dly_cnt = dly_cnt + 8'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dly_run <= 1'b0;
			dly_cnt <= '0;
			sda_drv <= 1'b0;
		end else if (ce) begin
			dly_run <= next_dly_run;
			dly_cnt <= next_dly_cnt;
			sda_drv <= next_sda_drv;
		end
	end

	// Open-drain pins: the level driven is always low, enabled low.
	assign scl_out = 1'b0;
	assign scl_oe_n = ~scl_drv;
	assign sda_out = 1'b0;
	assign sda_oe_n = ~sda_drv;

endmodule // ccb_bridge_cfg

// File: hdl/ccb_pkg.sv
package ccb_pkg;

	// Register offsets on the serial control bus.
	localparam logic [7:0] CCB_ADDR_CTRL1 = 8'h05;
	localparam logic [7:0] CCB_ADDR_CTRL2 = 8'h06;
	localparam logic [7:0] CCB_ADDR_IDENT = 8'h07;
	localparam logic [7:0] CCB_ADDR_TGT0 = 8'h08;
	localparam logic [7:0] CCB_ADDR_TGT1 = 8'h09;
	localparam logic [7:0] CCB_ADDR_ALIAS0 = 8'h10;
	localparam logic [7:0] CCB_ADDR_ALIAS1 = 8'h11;

	// Field positions in link_bus_control.
	localparam int CCB_C2_SEQ_ERR = 7;
	localparam int CCB_C2_SEQ_CLR = 6;
	localparam int CCB_C2_SDA_DLY_HI = 4;
	localparam int CCB_C2_SDA_DLY_LO = 3;
	localparam int CCB_C2_WR_LOCK = 2;
	localparam int CCB_C2_WD_FAST = 1;
	localparam int CCB_C2_WD_OFF = 0;

	// Field positions in the other registers.
	localparam int CCB_C1_PASS_ALL = 7;
	localparam int CCB_ID_HOLD = 0;
	localparam int CCB_ADDR7_HI = 7;
	localparam int CCB_ADDR7_LO = 1;

	// Reset values.
	localparam logic [7:0] CCB_CTRL1_RST = 8'h1e;
	localparam logic [7:0] CCB_CTRL2_RST = 8'h00;
	localparam logic [6:0] CCB_ADDR7_RST = 7'h00;
	localparam logic [7:0] CCB_RD_UNMAPPED = 8'h00;

	// Timing, in the units printed, and the system clock rate.
	localparam int CCB_CLK_MHZ = 250;
	localparam int CCB_SDA_DLY_BASE_NS = 250;
	localparam int CCB_SDA_DLY_STEP_NS = 50;
	localparam int CCB_WD_SLOW_S = 1;
	localparam int CCB_WD_FAST_US = 50;
	localparam int CCB_RCV_HALF_NS = 5000;
	localparam int CCB_RCV_PULSES = 9;

	// Derived cycle counts; a least time rounds up.
	localparam int CCB_WD_SLOW_CYC = CCB_WD_SLOW_S * CCB_CLK_MHZ * 1000000;
	localparam int CCB_WD_FAST_CYC = CCB_WD_FAST_US * CCB_CLK_MHZ;
	localparam int CCB_RCV_HALF_CYC = (CCB_RCV_HALF_NS * CCB_CLK_MHZ + 999) / 1000;

	// Bus recovery sequencer, Gray coded along the pulse path.
	typedef enum logic [1:0] {
		CCB_WD_IDLE = 2'b00,
		CCB_WD_LOW = 2'b01,
		CCB_WD_HIGH = 2'b11
	} ccb_wd_state_t;

endpackage

// File: hdl/ccb_xfer.sv
`timescale 1ns/100ps
// Carries one word per event from the link clock to the system clock by a toggle handshake.
module ccb_xfer #(
	parameter int W = 8
) (
	input wire logic clk_src,
	input wire logic srst_src,
	input wire logic src_valid,
	input wire logic [W-1:0] src_data,
	input wire logic clk_dst,
	input wire logic srst_dst,
	input wire logic ce,
	output logic dst_valid,
	output logic [W-1:0] dst_data
);

	logic src_tog;
	logic [W-1:0] src_hold;
	logic next_src_tog;
	logic [W-1:0] next_src_hold;
	logic tog_s1;
	logic tog_s2;
	logic tog_s3;
	logic next_dst_valid;
	logic [W-1:0] next_dst_data;

	// Source side: the held word stays put until the next event, so it is stable when sampled.
	always_comb begin
		next_src_tog = src_tog;
		next_src_hold = src_hold;
		if (src_valid) begin
			next_src_tog = ~src_tog;
			next_src_hold = src_data;
		end
	end

	always_ff @(posedge clk_src) begin
		if (srst_src) begin
			src_tog <= 1'b0;
			src_hold <= '0;
		end else begin
			src_tog <= next_src_tog;
			src_hold <= next_src_hold;
		end
	end

	// Destination side: the edge is seen between the second and third stages only.
	always_comb begin
		next_dst_valid = tog_s2 ^ tog_s3;
		next_dst_data = dst_data;
		if (tog_s2 ^ tog_s3) begin
			next_dst_data = src_hold;
		end
	end

	always_ff @(posedge clk_dst) begin
		if (srst_dst) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			dst_valid <= 1'b0;
			dst_data <= '0;
		end else if (ce) begin
			tog_s1 <= src_tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			dst_valid <= next_dst_valid;
			dst_data <= next_dst_data;
		end
	end

endmodule // ccb_xfer

// File: testbench/ccb_bridge_cfg_checker.sv
`timescale 1ns/100ps
// Watches the bridge pins for relations that must hold whatever the traffic is.
module ccb_bridge_cfg_checker
	import ccb_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rd_data,
	input wire logic txn_valid,
	input wire logic fwd_valid,
	input wire logic fwd_remapped,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_out,
	input wire logic sda_in,
	input wire logic bus_free,
	input wire logic rmt_wr_refused
);
	int low_cnt;
	int next_low_cnt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Length of the current recovery low phase, so a wrong half period shows at the rise.
	always_comb begin
		next_low_cnt = scl_oe_n ? 0 : low_cnt + 1;
	end
	always_ff @(posedge clk_sys) begin
		if (srst)
			low_cnt <= 0;
		else
			low_cnt <= next_low_cnt;
	end
	sequence s_ctl_rd;
		reg_rd && ce && reg_addr == CCB_ADDR_CTRL2;
	endsequence
	sequence s_wd_off;
		reg_wr && ce && reg_addr == CCB_ADDR_CTRL2 && reg_wdata[CCB_C2_WD_OFF];
	endsequence
	sequence s_sda_act;
		bus_free && $fell(sda_in);
	endsequence
	AST_RD_RSV: assert property (reg_rd && ce && (reg_addr == CCB_ADDR_TGT0 || reg_addr == CCB_ADDR_TGT1) |=> !reg_rd_data[0])
		else $error("target reserved bit read back as one");
	AST_SEQ_CLR: assert property (s_ctl_rd |=> !(reg_rd_data[CCB_C2_SEQ_ERR] && reg_rd_data[CCB_C2_SEQ_CLR]) && !reg_rd_data[5])
		else $error("error flag seen set while clear bit is one");
	AST_WD_OFF: assert property (s_wd_off |-> ##[1:3] (scl_oe_n && !bus_free))
		else $error("watchdog still active after disable");
	AST_RCV_LOW: assert property ($rose(scl_oe_n) |-> low_cnt == CCB_RCV_HALF_CYC)
		else $error("recovery low phase has wrong length");
	AST_FREE_DROP: assert property (s_sda_act |-> ##[1:6] !bus_free)
		else $error("bus free kept through activity");
	AST_FWD_CAUSE: assert property (fwd_valid && $past(ce) |-> $past(txn_valid))
		else $error("forward without a local transaction");
	AST_REMAP: assert property (fwd_remapped |-> fwd_valid)
		else $error("remap flag without forward");
	AST_REFUSE: assert property (rmt_wr_refused |=> !rmt_wr_refused)
		else $error("refusal pulse longer than one cycle");
	AST_OUT_LVL: assert property (scl_out == 1'h0 && sda_out == 1'h0)
		else $error("open drain output level not low");
endmodule // ccb_bridge_cfg_checker

bind ccb_bridge_cfg ccb_bridge_cfg_checker chk (.clk_sys, .srst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rd_data, .txn_valid, .fwd_valid, .fwd_remapped, .scl_out, .scl_oe_n, .sda_out, .sda_in, .bus_free,
	.rmt_wr_refused);

// File: testbench/ccb_link_model.sv
`timescale 1ns/100ps
// Far serializer: one link event per call, one link clock long.
module ccb_link_model (
	input wire logic clk_link,
	output logic lnk_seq_err,
	output logic lnk_id_valid,
	output logic [6:0] lnk_id,
	output logic lnk_wr_valid,
	output logic [7:0] lnk_wr_addr,
	output logic [7:0] lnk_wr_data
);
	// Idle payload shows junk, so sampling it outside a pulse is caught.
	initial begin
		lnk_seq_err = 1'h0;
		lnk_id_valid = 1'h0;
		lnk_wr_valid = 1'h0;
		lnk_id = 7'h55;
		lnk_wr_addr = 8'haa;
		lnk_wr_data = 8'h55;
	end
	// Kind 0 is a sequence error, 1 an identity load, 2 a register write.
	task send(input int k, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_link);
		#1;
		lnk_seq_err = (k == 0);
		lnk_id_valid = (k == 1);
		lnk_wr_valid = (k == 2);
		lnk_id = d[7:1];
		lnk_wr_addr = a;
		lnk_wr_data = d;
		@(posedge clk_link);
		#1;
		lnk_seq_err = 1'h0;
		lnk_id_valid = 1'h0;
		lnk_wr_valid = 1'h0;
		lnk_id = ~d[7:1];
		lnk_wr_addr = ~a;
		lnk_wr_data = ~d;
	endtask
endmodule // ccb_link_model

// File: testbench/ctrl_channel_i2c_config_tb_top.sv
`timescale 1ns/100ps
module ctrl_channel_i2c_config_tb_top;
	import ccb_pkg::*;
	logic clk_sys, srst, ce, reg_wr, reg_rd, txn_valid, scl_in, sda_in, sda_req, clk_link, srst_link;
	logic [7:0] reg_addr, reg_wdata, reg_rd_data, lnk_wr_addr, lnk_wr_data;
	logic [6:0] txn_addr, fwd_addr, lnk_id;
	logic fwd_valid, fwd_remapped, scl_out, scl_oe_n, sda_out, sda_oe_n, bus_free, rmt_wr_refused;
	logic lnk_seq_err, lnk_id_valid, lnk_wr_valid, tb_scl, tb_sda;
	int bad_count, compares, nref, n, p;
	int m [0:31];
	// The bus lines are a wired AND of the bench drive and the device pull-downs.
	assign scl_in = tb_scl & scl_oe_n;
	assign sda_in = tb_sda & sda_oe_n;
	ccb_bridge_cfg #(.WD_SLOW_CYC(200), .WD_FAST_CYC(50)) uut (.clk_sys, .srst, .ce, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rd_data, .txn_valid, .txn_addr, .fwd_valid, .fwd_addr, .fwd_remapped, .scl_in,
		.sda_in, .scl_out, .scl_oe_n, .sda_out, .sda_oe_n, .sda_req, .bus_free, .rmt_wr_refused, .clk_link,
		.srst_link, .lnk_seq_err, .lnk_id_valid, .lnk_id, .lnk_wr_valid, .lnk_wr_addr, .lnk_wr_data);
	ccb_link_model far (.clk_link, .lnk_seq_err, .lnk_id_valid, .lnk_id, .lnk_wr_valid, .lnk_wr_addr,
		.lnk_wr_data);
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		clk_link = 1'h0;
		#7.3;
		forever #62.5 clk_link = ~clk_link;
	end
	// Dropped remote writes are one-cycle pulses, so counting edges counts drops.
	always @(posedge clk_sys) if (rmt_wr_refused === 1'h1) nref++;
	task summarize();
		$display("counts: %0d compares, %0d mismatches", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task tmo();
		bad_count++;
		summarize();
	endtask
	task chk8(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		chk8({7'h0, g}, {7'h0, e});
	endtask
	task step(input int c);
		repeat (c) @(negedge clk_sys);
	endtask
	// Register write; the model keeps read-only and reserved bits as the device must.
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clk_sys);
		reg_wr = 1'h0;
		case (a)
			8'h05: m[5] = d;
			8'h06: m[6] = d[6] ? (d & 8'h5f) : ((m[6] & 8'h80) | (d & 8'h5f));
			8'h07: m[7] = d[0] ? d : (m[7] & 8'hfe);
			8'h08, 8'h09, 8'h10, 8'h11: m[a] = d & 8'hfe;
			default: ;
		endcase
	endtask
	task rd(input logic [7:0] a);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'h1;
		@(negedge clk_sys);
		reg_rd = 1'h0;
		chk8(reg_rd_data, m[a][7:0]);
	endtask
	task lnk(input int k, input logic [7:0] a, input logic [7:0] d);
		far.send(k, a, d);
		step(8);
	endtask
	task txn(input logic [6:0] a);
		logic ev, er;
		logic [6:0] ea;
		ev = m[5][7];
		er = 1'h0;
		ea = a;
		if (m[16][7:1] != 7'h0 && a == m[16][7:1]) begin
			{ev, er, ea} = {2'h3, m[8][7:1]};
		end else if (m[17][7:1] != 7'h0 && a == m[17][7:1]) begin
			{ev, er, ea} = {2'h3, m[9][7:1]};
		end
		@(negedge clk_sys);
		txn_addr = a;
		txn_valid = 1'h1;
		@(negedge clk_sys);
		txn_valid = 1'h0;
		chk1(fwd_valid, ev);
		if (ev) chk8({1'h0, fwd_addr}, {1'h0, ea});
		chk1(fwd_remapped, er);
	endtask
	// A hang anywhere ends the run through the same report.
	initial begin
		#400000;
		tmo();
	end
	initial begin
		{srst, srst_link, ce, reg_wr, reg_rd, txn_valid, sda_req} = 7'h70;
		{reg_addr, reg_wdata, txn_addr} = 23'h0;
		{tb_scl, tb_sda} = 2'h3;
		m = '{default: 0};
		m[5] = 8'h1e;
		void'($urandom(32'hb76f));
		step(2);
		srst = 1'h0;
		@(posedge clk_link);
		#1 srst_link = 1'h0;
		for (int a = 5; a < 19; a++) rd(a[7:0]);
		$display("test reset_values done");
		for (int a = 5; a < 19; a++) begin
			wr(a[7:0], 8'($urandom));
			rd(a[7:0]);
		end
		$display("test random_access done");
		wr(8'h06, 8'h01);
		lnk(0, 8'h0, 8'h0);
		m[6] = 8'h81;
		rd(8'h06);
		wr(8'h06, 8'h41);
		rd(8'h06);
		lnk(0, 8'h0, 8'h0);
		rd(8'h06);
		wr(8'h06, 8'h01);
		lnk(0, 8'h0, 8'h0);
		m[6] = 8'h81;
		rd(8'h06);
		$display("test sequence_error done");
		wr(8'h07, 8'h00);
		lnk(1, 8'h0, 8'h5a);
		m[7] = 8'h5a;
		rd(8'h07);
		wr(8'h07, 8'h35);
		lnk(1, 8'h0, 8'hc4);
		rd(8'h07);
		$display("test identity done");
		p = nref;
		lnk(2, 8'h08, 8'h77);
		m[8] = 8'h76;
		rd(8'h08);
		wr(8'h06, 8'h05);
		lnk(2, 8'h08, 8'h33);
		rd(8'h08);
		chk8(8'(nref - p), 8'h1);
		$display("test remote_write done");
		wr(8'h05, 8'h1e);
		wr(8'h10, 8'h22);
		wr(8'h11, 8'h44);
		wr(8'h08, 8'h90);
		wr(8'h09, 8'h92);
		for (int i = 0; i < 24; i++) begin
			if (i == 12) wr(8'h05, 8'h9e);
			txn(i[1:0] == 2'h0 ? 7'h11 : i[1:0] == 2'h1 ? 7'h22 : 7'($urandom));
		end
		$display("test remap done");
		// Idle time to expiry, fast then slow, after one blip of activity.
		for (int f = 1; f >= 0; f--) begin
			wr(8'h06, {6'h0, f[0], 1'h0});
			tb_sda = 1'h0;
			step(1);
			tb_sda = 1'h1;
			// A free flag left from the previous pass only drops once the blip has been synchronised.
			step(2);
			n = 2;
			while (bus_free !== 1'h1 && n < 400) begin step(1); n++; end
			if (n >= 400) tmo();
			chk1(n >= (f ? 48 : 198) && n <= (f ? 58 : 208), 1'h1);
		end
		wr(8'h06, 8'h02);
		tb_sda = 1'h0;
		n = 0;
		while (scl_oe_n !== 1'h0 && n < 400) begin step(1); n++; end
		if (n >= 400) tmo();
		p = 0;
		// A train ends where the high gap outgrows the recovery half period.
		do begin
			p++;
			n = 0;
			while (scl_oe_n !== 1'h1 && n < 1400) begin step(1); n++; end
			if (n >= 1400) tmo();
			n = 0;
			while (scl_oe_n === 1'h1 && n < 1400) begin step(1); n++; end
		end while (n < 1270 && p < 20);
		chk8(p[7:0], 8'h9);
		n = 0;
		while (scl_oe_n !== 1'h1 && n < 1400) begin step(1); n++; end
		if (n >= 1400) tmo();
		wr(8'h06, 8'h03);
		n = 0;
		for (int i = 0; i < 3000; i++) begin
			if (i == 1500) tb_sda = 1'h1;
			step(1);
			if (scl_oe_n !== 1'h1 || bus_free !== 1'h0) n++;
		end
		chk1(n == 0, 1'h1);
		$display("test watchdog done");
		for (int c = 0; c < 4; c++) begin
			wr(8'h06, {3'h0, c[1:0], 3'h1});
			sda_req = ~sda_req;
			tb_scl = 1'h0;
			n = 0;
			while (sda_oe_n !== ~sda_req && n < 200) begin step(1); n++; end
			if (n >= 200) tmo();
			chk1(n >= (253 + 50 * c) / 4 + 2 && n <= (253 + 50 * c) / 4 + 6, 1'h1);
			tb_scl = 1'h1;
			step(4);
		end
		$display("test sda_delay done");
		// With the clock enable low a register write must leave no trace.
		ce = 1'h0;
		p = m[9];
		wr(8'h09, 8'h5c);
		ce = 1'h1;
		m[9] = p;
		rd(8'h09);
		$display("test clock_enable done");
		summarize();
	end
endmodule // ctrl_channel_i2c_config_tb_top
